/* inc/pls_pkg.sv */
package pls_pkg;
  localparam int STAGE_CNT = 8;
  typedef logic [STAGE_CNT-1:0] pls_stage_vec_t;
  // Idle level that the edge detectors assume after reset
  localparam logic PREV_RST_VAL = 1'b0;
  localparam int FIRST_STAGE = 0;
endpackage : pls_pkg

/* inc/pls_ctl_if.sv */
interface pls_ctl_if;
  logic shift_pulse;
  logic ser_clk_now;
  logic inhibit_now;
  modport qual (output shift_pulse, output ser_clk_now, output inhibit_now);
  modport core (input shift_pulse, input ser_clk_now, input inhibit_now);
endinterface : pls_ctl_if

/* design/pls_clk_qual.sv */
module pls_clk_qual (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ser_clk,
  input wire logic clock_inhibit,
  pls_ctl_if.qual ctl
);
  import pls_pkg::*;

  logic prev_clk_r;
  logic prev_inh_r;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      prev_clk_r <= PREV_RST_VAL;
      prev_inh_r <= PREV_RST_VAL;
    end else begin
      prev_clk_r <= ser_clk;
      prev_inh_r <= clock_inhibit;
    end
  end

  always_comb begin
    ctl.ser_clk_now = ser_clk;
    ctl.inhibit_now = clock_inhibit;
    ctl.shift_pulse = (ser_clk && !prev_clk_r && !clock_inhibit) ||
                      (clock_inhibit && !prev_inh_r && !ser_clk);
  end

  property p_inhibit_blocks;
    @(posedge sys_clk) disable iff (rst)
      !$past(rst) && clock_inhibit && $past(clock_inhibit) |-> !ctl.shift_pulse;
  endproperty
  a_inhibit_blocks: assert property (p_inhibit_blocks) else $error("shift while inhibit held high");

  property p_clk_edge_shifts;
    @(posedge sys_clk) disable iff (rst)
      !clock_inhibit && $rose(ser_clk) |-> ctl.shift_pulse;
  endproperty
  a_clk_edge_shifts: assert property (p_clk_edge_shifts) else $error("clock edge did not shift");

  property p_inh_edge_shifts;
    @(posedge sys_clk) disable iff (rst)
      !ser_clk && $rose(clock_inhibit) |-> ctl.shift_pulse;
  endproperty
  a_inh_edge_shifts: assert property (p_inh_edge_shifts) else $error("inhibit edge did not shift");
endmodule : pls_clk_qual

/* design/pls_shift_top.sv */
// Notes on behaviour
// - Load low copies parallel inputs into stages.
// - Load acts without waiting for clock edges.
// - During load, output shows last parallel input.
// - Load high, no clock: stages hold.
// - Qualified rising edge takes serial input first.
// - Stages move toward output; last drops.
// - Outputs show last stage and complement.
// - Inhibit high ignores clock pulses.
// - Clock and inhibit are interchangeable edges.
// - Load overrides clocking; high levels hold.
// - Stages have no defined power-up value.
module pls_shift_top #(
  parameter int N = pls_pkg::STAGE_CNT
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic shift_load_n,
  input wire logic ser_clk,
  input wire logic clock_inhibit,
  input wire logic ser_in,
  input wire logic [N-1:0] par_in,
  output logic q,
  output logic q_n
);
  import pls_pkg::*;

  logic [N-1:0] stage_r;
  logic [N-1:0] stage_nxt;
  logic [N-1:0] shifted;
  logic stages_known_r;

  pls_ctl_if ctl_bus ();

  pls_clk_qual u_qual (
    .sys_clk(sys_clk),
    .rst(rst),
    .ser_clk(ser_clk),
    .clock_inhibit(clock_inhibit),
    .ctl(ctl_bus)
  );

  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_stage
      if (i == FIRST_STAGE) begin : g_first
        assign shifted[i] = ser_in;
      end else begin : g_rest
        assign shifted[i] = stage_r[i-1];
      end
    end
  endgenerate

  always_comb begin
    if (!shift_load_n) begin
      stage_nxt = par_in;
    end else if (ctl_bus.shift_pulse) begin
      stage_nxt = shifted;
    end else begin
      stage_nxt = stage_r;
    end
  end

  always_ff @(posedge sys_clk) begin
    stage_r <= stage_nxt;
  end

  // Output flops fed from the next value so they track stage_r without a lag
  // last stage and complement
  always_ff @(posedge sys_clk) begin
    q <= stage_nxt[N-1];
    q_n <= ~stage_nxt[N-1];
  end

  // Checker aid only: stages are unknown until a load, so stage checks wait for one.
  // A load in the same cycle as reset still counts, since reset leaves the stages alone.
  always_ff @(posedge sys_clk) begin
    if (!shift_load_n) begin
      stages_known_r <= 1'b1;
    end else if (rst) begin
      stages_known_r <= 1'b0;
    end
  end

  // The pin views from the qualifier let the checks below restate its decision
  // from the sampled levels, independent of its edge flops.
  sequence s_shift_cond;
    stages_known_r && shift_load_n && ctl_bus.shift_pulse;
  endsequence

  sequence s_hold_cond;
    stages_known_r && shift_load_n && !ctl_bus.shift_pulse;
  endsequence

  sequence s_both_high;
    stages_known_r && shift_load_n && ctl_bus.ser_clk_now && ctl_bus.inhibit_now;
  endsequence

  sequence s_inhibit_held;
    !$past(rst) && stages_known_r && shift_load_n && ctl_bus.inhibit_now && $past(ctl_bus.inhibit_now);
  endsequence

  sequence s_clk_rise;
    stages_known_r && shift_load_n && !ctl_bus.inhibit_now && ctl_bus.ser_clk_now && !$past(ctl_bus.ser_clk_now);
  endsequence

  sequence s_inh_rise;
    stages_known_r && shift_load_n && !ctl_bus.ser_clk_now && ctl_bus.inhibit_now && !$past(ctl_bus.inhibit_now);
  endsequence

  // Load, one quiet cycle, then the first edge: the usual opening of a read
  sequence s_load_release;
    !shift_load_n ##1 (shift_load_n && !ctl_bus.shift_pulse) ##1 (shift_load_n && ctl_bus.shift_pulse);
  endsequence

  property p_load_copies;
    @(posedge sys_clk) disable iff (rst)
      !shift_load_n |=> stage_r == $past(par_in);
  endproperty
  a_load_copies: assert property (p_load_copies) else $error("load did not copy inputs");

  property p_load_follows;
    @(posedge sys_clk) disable iff (rst)
      !shift_load_n ##1 !shift_load_n |=> stage_r == $past(par_in) && $past(stage_r) == $past(par_in, 2);
  endproperty
  a_load_follows: assert property (p_load_follows) else $error("stages did not follow inputs");

  property p_load_output;
    @(posedge sys_clk) disable iff (rst)
      !shift_load_n |=> q == $past(par_in[N-1]) && q_n == !$past(par_in[N-1]);
  endproperty
  a_load_output: assert property (p_load_output) else $error("output wrong during load");

  property p_hold;
    @(posedge sys_clk) disable iff (rst)
      s_hold_cond |=> stage_r == $past(stage_r);
  endproperty
  a_hold: assert property (p_hold) else $error("stages changed without edge");

  property p_serial_in;
    @(posedge sys_clk) disable iff (rst)
      s_shift_cond |=> stage_r[FIRST_STAGE] == $past(ser_in);
  endproperty
  a_serial_in: assert property (p_serial_in) else $error("serial input not captured");

  property p_shift_move;
    @(posedge sys_clk) disable iff (rst)
      s_shift_cond |=> stage_r[N-1:1] == $past(stage_r[N-2:0]);
  endproperty
  a_shift_move: assert property (p_shift_move) else $error("stages did not move");

  property p_outputs;
    @(posedge sys_clk) disable iff (rst)
      stages_known_r |-> q == stage_r[N-1] && q_n == !stage_r[N-1];
  endproperty
  a_outputs: assert property (p_outputs) else $error("outputs not tied to last stage");

  property p_load_wins;
    @(posedge sys_clk) disable iff (rst)
      !shift_load_n && ctl_bus.shift_pulse |=> stage_r == $past(par_in);
  endproperty
  a_load_wins: assert property (p_load_wins) else $error("edge beat load");

  property p_shift_output;
    @(posedge sys_clk) disable iff (rst)
      s_shift_cond |=> q == $past(stage_r[N-2]) && q_n == !$past(stage_r[N-2]);
  endproperty
  a_shift_output: assert property (p_shift_output) else $error("output did not take next stage");

  property p_both_high_hold;
    @(posedge sys_clk) disable iff (rst)
      s_both_high |=> stage_r == $past(stage_r);
  endproperty
  a_both_high_hold: assert property (p_both_high_hold) else $error("both clocks high changed stages");

  property p_no_pulse_both_high;
    @(posedge sys_clk) disable iff (rst)
      ctl_bus.ser_clk_now && ctl_bus.inhibit_now |-> !ctl_bus.shift_pulse;
  endproperty
  a_no_pulse_both_high: assert property (p_no_pulse_both_high) else $error("shift with both clocks high");

  property p_inhibit_hold;
    @(posedge sys_clk) disable iff (rst)
      s_inhibit_held |=> stage_r == $past(stage_r) && q == $past(q);
  endproperty
  a_inhibit_hold: assert property (p_inhibit_hold) else $error("stages moved while inhibit held");

  property p_clk_rise_shift;
    @(posedge sys_clk) disable iff (rst)
      s_clk_rise |=> stage_r[N-1:1] == $past(stage_r[N-2:0]) && stage_r[FIRST_STAGE] == $past(ser_in);
  endproperty
  a_clk_rise_shift: assert property (p_clk_rise_shift) else $error("clock rise did not shift");

  property p_inh_rise_shift;
    @(posedge sys_clk) disable iff (rst)
      s_inh_rise |=> stage_r[N-1:1] == $past(stage_r[N-2:0]) && stage_r[FIRST_STAGE] == $past(ser_in);
  endproperty
  a_inh_rise_shift: assert property (p_inh_rise_shift) else $error("inhibit rise did not shift");

  property p_complement;
    @(posedge sys_clk) disable iff (rst)
      stages_known_r |-> q_n == !q;
  endproperty
  a_complement: assert property (p_complement) else $error("outputs not complementary");

  property p_hold_output;
    @(posedge sys_clk) disable iff (rst)
      s_hold_cond |=> q == $past(q) && q_n == $past(q_n);
  endproperty
  a_hold_output: assert property (p_hold_output) else $error("output changed without edge");

  property p_load_then_shift;
    @(posedge sys_clk) disable iff (rst)
      s_load_release |=> q == $past(par_in[N-2], 3);
  endproperty
  a_load_then_shift: assert property (p_load_then_shift) else $error("first shift after load wrong");
endmodule : pls_shift_top

/* testbench/pls_ctrl_model.sv */
module pls_ctrl_model (
  input wire logic sys_clk,
  input wire logic q,
  output logic shift_load_n,
  output logic ser_clk
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    shift_load_n = 1'b1;
    ser_clk = 1'b0;
  end
  // clock out what the stages hold
  task automatic shift_bits(input int edges, output logic [15:0] v);
    v = '0;
    for (int i = 0; i < edges; i++) begin
      // Low for a full cycle so each rise is seen
      @(negedge sys_clk) v = {v[14:0], q};
      ser_clk = 1'b1;
      @(negedge sys_clk) ser_clk = 1'b0;
    end
  endtask : shift_bits
  task automatic read_word(input int edges, output logic [15:0] v);
    @(negedge sys_clk) shift_load_n = 1'b0;
    @(negedge sys_clk) shift_load_n = 1'b1;
    shift_bits(edges, v);
  endtask : read_word
  task automatic set_load(input logic lvl);
    @(negedge sys_clk) shift_load_n = lvl;
  endtask : set_load
endmodule : pls_ctrl_model

/* testbench/pls_shift_top_tb.sv */
module pls_shift_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import pls_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic clock_inhibit = 1'b0;
  logic ser_in = 1'b0;
  pls_stage_vec_t par_in = '0;
  logic shift_load_n, ser_clk, q, q_n;
  logic [15:0] v;
  int failures = 0;
  int tests_run = 0;
  pls_shift_top i_pls_shift_top (.sys_clk(sys_clk), .rst(rst), .shift_load_n(shift_load_n), .ser_clk(ser_clk),
    .clock_inhibit(clock_inhibit), .ser_in(ser_in), .par_in(par_in), .q(q), .q_n(q_n));
  pls_ctrl_model i_pls_ctrl_model (.sys_clk(sys_clk), .q(q), .shift_load_n(shift_load_n), .ser_clk(ser_clk));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report
  // Sixteen edges: the loaded byte, then eight copies of the serial input
  task automatic t_load_read(input pls_stage_vec_t p, input logic s);
    @(negedge sys_clk) par_in = p;
    ser_in = s;
    i_pls_ctrl_model.read_word(16, v);
    check(v, {p, {8{s}}});
    @(negedge sys_clk) check({15'h0, q_n}, {15'h0, ~s});
    $display("load_read %h done", p);
  endtask : t_load_read
  task automatic t_inhibit();
    @(negedge sys_clk) clock_inhibit = 1'b1;
    par_in = 8'hb4;
    i_pls_ctrl_model.read_word(4, v);
    check(v, 16'h000f);
    @(negedge sys_clk) clock_inhibit = 1'b0;
    // Inhibit rising with the clock held low acts as the clock
    @(negedge sys_clk) clock_inhibit = 1'b1;
    @(negedge sys_clk) check({14'h0, q, q_n}, 16'h0001);
    clock_inhibit = 1'b0;
    $display("inhibit done");
  endtask : t_inhibit
  // Load held low: stages follow par_in and an inhibit rise meanwhile is ignored
  task automatic t_load_follow();
    @(negedge sys_clk) par_in = 8'h3c;
    i_pls_ctrl_model.set_load(1'b0);
    @(negedge sys_clk) check({14'h0, q, q_n}, 16'h0001);
    par_in = 8'ha5;
    clock_inhibit = 1'b1;
    @(negedge sys_clk) check({14'h0, q, q_n}, 16'h0002);
    clock_inhibit = 1'b0;
    i_pls_ctrl_model.set_load(1'b1);
    repeat (3) @(negedge sys_clk);
    i_pls_ctrl_model.shift_bits(8, v);
    check(v, 16'h00a5);
    $display("load_follow done");
  endtask : t_load_follow
  initial begin
    forever #10 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (5) @(negedge sys_clk);
    rst = 1'b0;
    t_load_read(8'hb4, 1'b1);
    t_load_read(8'h4b, 1'b0);
    t_load_follow();
    t_inhibit();
    final_report();
  end
  // Whole run is under two hundred cycles
  initial begin
    #20us;
    failures++;
    final_report();
  end
endmodule : pls_shift_top_tb
